//--- hw/acd_decoder.v
// Two-wire write decoder and conversion sequence control
`timescale 1ns/1ps
`default_nettype none
`include "acd_regs.vh"

module acd_decoder (
  input wire sys_clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire addr_strap,
  input wire conv_done,
  input wire [3:0] mon_rd_addr,
  output reg [7:0] mon_rd_data,
  output reg [7:0] conversion_configuration_q,
  output reg [7:0] setup_q,
  output wire [1:0] scan_select,
  output wire [1:0] channel_select,
  output wire input_pairing,
  output wire conv_bipolar,
  output wire conv_ext_clock,
  output wire ain3_is_reference,
  output wire ref_powered,
  output wire mon_readback_en,
  output reg [3:0] mon_count_q,
  output reg alarm_clear,
  output reg hs_mode_q,
  output reg adc_powered_q,
  output reg seq_active_q,
  output reg conv_req_q,
  output reg [1:0] conv_channel_q,
  output reg result_wr_q,
  output reg [3:0] result_idx_q
);

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  wire [2:0] pins_s;
  reg scl_p_q;
  reg sda_p_q;
  wire scl_s = pins_s[0];
  wire sda_s = pins_s[1];
  wire strap_s = pins_s[2];

  acd_sync #(.W(3)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({addr_strap, sda_in, scl_in}),
    .sync_out(pins_s)
  );

  always @(posedge sys_clk) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  // Line conditions need SCL high on two samples in a row
  wire bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ----------------------------------------------------------------
  // Decoded fields
  // ----------------------------------------------------------------
  assign scan_select = conversion_configuration_q[`ACD_CFG_SCAN_HI:
                                                  `ACD_CFG_SCAN_LO];
  assign channel_select = conversion_configuration_q[`ACD_CFG_CS_HI:
                                                     `ACD_CFG_CS_LO];
  assign input_pairing = conversion_configuration_q[`ACD_CFG_PAIRING];
  assign mon_readback_en = conversion_configuration_q[`ACD_CFG_RB_HI] &
                           conversion_configuration_q[`ACD_CFG_RB_LO];
  // Polarity only matters for differential pairs
  assign conv_bipolar = ~input_pairing & setup_q[`ACD_SET_POLARITY];
  assign conv_ext_clock = setup_q[`ACD_SET_EXT_CLK];
  assign ain3_is_reference = setup_q[`ACD_SET_SEL_LO];
  assign ref_powered = setup_q[`ACD_SET_SEL_HI] &
                       setup_q[`ACD_SET_REF_PWR];

  // ----------------------------------------------------------------
  // Bit engine
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ADDR = 4'b0010;
  localparam [3:0] ST_WR = 4'b0100;
  localparam [3:0] ST_RD = 4'b1000;

  reg [3:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg ack_q;
  reg [3:0] mon_left_q;
  // No reset: monitor bytes are unknown until written
  reg [7:0] mon_mem [0:12];
  reg start_seq;
  reg end_seq;
  reg addr_hit;
  // Strap pin picks one of two neighbouring addresses
  wire [6:0] own_addr = {`ACD_ADDR_BASE, strap_s};

  assign sda_out = 1'b0;
  assign sda_oe = ack_q;

  // Slots past the last monitor byte read as zero
  always @(posedge sys_clk) begin
    if (rst) begin
      mon_rd_data <= 8'h00;
    end else if (mon_rd_addr < `ACD_MON_BYTES) begin
      mon_rd_data <= mon_mem[mon_rd_addr];
    end else begin
      mon_rd_data <= 8'h00;
    end
  end

  always @(posedge sys_clk) begin
    start_seq <= 1'b0;
    end_seq <= 1'b0;
    alarm_clear <= 1'b0;
    addr_hit <= 1'b0;
    if (rst) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ack_q <= 1'b0;
      mon_left_q <= 4'h0;
      mon_count_q <= 4'h0;
      hs_mode_q <= 1'b0;
      conversion_configuration_q <= `ACD_CFG_RESET;
      setup_q <= `ACD_SET_RESET;
      start_seq <= 1'b0;
      end_seq <= 1'b0;
      alarm_clear <= 1'b0;
    end else if (bus_stop) begin
      // Monitor bytes already stored stay put
      state_q <= ST_IDLE;
      ack_q <= 1'b0;
      mon_left_q <= 4'h0;
      // A repeated START keeps fast timing; only STOP drops it
      hs_mode_q <= 1'b0;
      end_seq <= 1'b1;
    end else if (bus_start) begin
      state_q <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      ack_q <= 1'b0;
      mon_left_q <= 4'h0;
      end_seq <= 1'b1;
    end else if (state_q != ST_IDLE) begin
      if (scl_rise && bit_cnt_q < 4'h8) begin
        shift_q <= {shift_q[6:0], sda_s};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end else if (scl_rise) begin
        bit_cnt_q <= 4'h9;
        // Master NACK after a read byte ends a bus-clocked run
        if (state_q == ST_RD && sda_s) begin
          end_seq <= 1'b1;
        end
      end else if (scl_fall && bit_cnt_q == 4'h9) begin
        ack_q <= 1'b0;
        bit_cnt_q <= 4'h0;
      end else if (scl_fall && bit_cnt_q == 4'h8) begin
        case (state_q)
          ST_ADDR: begin
            if (shift_q[7:1] == own_addr) begin
              ack_q <= 1'b1;
              addr_hit <= 1'b1;
              if (shift_q[0]) begin
                state_q <= ST_RD;
                start_seq <= 1'b1;
              end else begin
                state_q <= ST_WR;
              end
            end else if (shift_q[7:3] == `ACD_HS_CODE) begin
              // Master code is left unanswered, then fast timing
              hs_mode_q <= 1'b1;
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_IDLE;
            end
          end
          ST_WR: begin
            ack_q <= 1'b1;
            if (mon_left_q != 4'h0) begin
              mon_mem[`ACD_MON_BYTES - mon_left_q] <= shift_q;
              mon_left_q <= mon_left_q - 4'h1;
              mon_count_q <= `ACD_MON_BYTES - mon_left_q + 4'h1;
            end else if (shift_q[`ACD_BYTE_SELECT]) begin
              setup_q <= shift_q;
              if (!shift_q[`ACD_SET_RESET_N]) begin
                conversion_configuration_q <= `ACD_CFG_RESET;
                alarm_clear <= 1'b1;
              end
              if (shift_q[`ACD_SET_MON]) begin
                mon_left_q <= `ACD_MON_BYTES;
                mon_count_q <= 4'h0;
              end
            end else begin
              conversion_configuration_q <= shift_q;
            end
          end
          default: begin
            // Read-out is handled elsewhere; stay until STOP or Sr
            ack_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequence
  // ----------------------------------------------------------------
  reg busy_q;
  reg [1:0] next_ch_q;
  reg [3:0] done_cnt_q;
  reg [1:0] top_ch;
  reg last_conv;
  wire multi = (scan_select == `ACD_SCAN_RANGE) ||
               (scan_select == `ACD_SCAN_MONITOR);
  wire monitor = (scan_select == `ACD_SCAN_MONITOR);

  always @* begin
    top_ch = channel_select;
    if (multi && ain3_is_reference && channel_select == 2'b11) begin
      top_ch = 2'b10;
    end
    case (scan_select)
      `ACD_SCAN_RANGE: last_conv = (conv_channel_q == top_ch);
      `ACD_SCAN_REPEAT: last_conv =
        (done_cnt_q == `ACD_REPEAT_COUNT - 4'h1);
      `ACD_SCAN_MONITOR: last_conv = (conv_channel_q == top_ch);
      default: last_conv = 1'b1;
    endcase
  end

  // A conv_done with no request outstanding is dropped, so a stray
  // pulse cannot write a result slot
  always @(posedge sys_clk) begin
    conv_req_q <= 1'b0;
    result_wr_q <= 1'b0;
    if (rst) begin
      adc_powered_q <= 1'b0;
      seq_active_q <= 1'b0;
      busy_q <= 1'b0;
      next_ch_q <= 2'b00;
      done_cnt_q <= 4'h0;
      conv_channel_q <= 2'b00;
      result_idx_q <= 4'h0;
      conv_req_q <= 1'b0;
      result_wr_q <= 1'b0;
    end else if (start_seq) begin
      adc_powered_q <= 1'b1;
      seq_active_q <= 1'b1;
      busy_q <= 1'b0;
      next_ch_q <= multi ? 2'b00 : channel_select;
      done_cnt_q <= 4'h0;
      result_idx_q <= 4'h0;
    end else if (end_seq && (conv_ext_clock || !seq_active_q)) begin
      // Bus-clocked conversions end only with the transfer
      adc_powered_q <= 1'b0;
      seq_active_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (seq_active_q && !busy_q) begin
      conv_req_q <= 1'b1;
      conv_channel_q <= next_ch_q;
      busy_q <= 1'b1;
    end else if (seq_active_q && conv_done) begin
      busy_q <= 1'b0;
      result_wr_q <= 1'b1;
      result_idx_q <= result_idx_q + 4'h1;
      done_cnt_q <= done_cnt_q + 4'h1;
      next_ch_q <= multi ? conv_channel_q + 2'b01 : channel_select;
      if (last_conv) begin
        done_cnt_q <= 4'h0;
        next_ch_q <= multi ? 2'b00 : channel_select;
        if (!monitor && !conv_ext_clock) begin
          // No STOP needed: sleep once memory holds the set
          seq_active_q <= 1'b0;
          adc_powered_q <= 1'b0;
        end
        if (!monitor) begin
          result_idx_q <= 4'h0;
        end
      end
    end

    // Any matching address wakes the converter, write or read
    if (!rst && addr_hit) begin
      adc_powered_q <= 1'b1;
    end
  end

endmodule

`default_nettype wire

//--- pkg/acd_regs.vh
// Constants for the command decoder: addresses, fields, resets, counts
// Behaviour
// - MSB zero marks a configuration byte
// - Scan 00 converts channel 0 up to top
// - Scan 01 converts selected channel eight times
// - Scan 10 repeats channel 0..top without stopping
// - Scan 11 converts selected channel exactly once; with external clock the code repeats it until idle
// - Readback bits 11 expose monitor setup data
// - Pairing bit: one single-ended, zero differential pairs
// - Single-ended forces unipolar, polarity bit ignored
// - START, address, write bit; address byte acknowledged
// - MSB one routes byte to setup register
// - Setup reset bit restores configuration default
// - Monitor flag admits up to 13 further bytes
// - Monitor data may stop anywhere; bytes kept
// - STOP in high-speed mode returns normal timing
// - External clock: idle only after STOP or Sr; code also idles on a master NACK after a read byte
// - Internal clock: power down after last result
// - Idle watches address; match powers converter up
// - Input three omitted from scans when reference
// - Read starts sequence; results in conversion order
// - Reference select encoding and power bit
// - Reset bit clears alarm and configuration only
// - Monitor flag extends write by 104 bits
// - Setup bit 4 keeps internal reference powered; code powers it only when bit 6 is also set
`ifndef ACD_REGS_VH
`define ACD_REGS_VH

// ----------------------------------------------------------------
// Configuration byte fields
// ----------------------------------------------------------------
`define ACD_CFG_RESET 8'h01
`define ACD_CFG_SCAN_HI 6
`define ACD_CFG_SCAN_LO 5
`define ACD_CFG_RB_HI 4
`define ACD_CFG_RB_LO 3
`define ACD_CFG_CS_HI 2
`define ACD_CFG_CS_LO 1
`define ACD_CFG_PAIRING 0

// ----------------------------------------------------------------
// Setup byte fields
// ----------------------------------------------------------------
`define ACD_SET_RESET 8'h82
`define ACD_SET_SEL_HI 6
`define ACD_SET_SEL_LO 5
`define ACD_SET_REF_PWR 4
`define ACD_SET_EXT_CLK 3
`define ACD_SET_POLARITY 2
`define ACD_SET_RESET_N 1
`define ACD_SET_MON 0

// ----------------------------------------------------------------
// Codes and counts
// ----------------------------------------------------------------
`define ACD_BYTE_SELECT 7
`define ACD_SCAN_RANGE 2'b00
`define ACD_SCAN_REPEAT 2'b01
`define ACD_SCAN_MONITOR 2'b10
`define ACD_SCAN_SINGLE 2'b11
`define ACD_HS_CODE 5'b0000_1
`define ACD_ADDR_BASE 6'b01_1010
`define ACD_MON_BYTES 4'hd
`define ACD_REPEAT_COUNT 4'h8

`endif

//--- hw/acd_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module acd_sync #(
  parameter W = 1
) (
  input wire sys_clk,
  input wire rst,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  genvar i;

  always @(posedge sys_clk) begin
    if (rst) begin
      s1_q <= {W{1'b1}};
      s2_q <= {W{1'b1}};
      s3_q <= {W{1'b1}};
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once stages two and three agree
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge sys_clk) begin
        if (rst) begin
          sync_out[i] <= 1'b1;
        end else if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

//--- dv/acd_checker_props.sv
// Port-level assertions for the command decoder
`timescale 1ns/1ps
`default_nettype none
`include "acd_regs.vh"
module acd_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic conv_done,
  input wire logic [7:0] conversion_configuration_q,
  input wire logic [1:0] scan_select,
  input wire logic [1:0] channel_select,
  input wire logic input_pairing,
  input wire logic conv_bipolar,
  input wire logic ain3_is_reference,
  input wire logic mon_readback_en,
  input wire logic alarm_clear,
  input wire logic seq_active_q,
  input wire logic conv_req_q,
  input wire logic [1:0] conv_channel_q,
  input wire logic result_wr_q
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence s_fin;
    conv_done && seq_active_q;
  endsequence
  sequence s_pick;
    conv_req_q && scan_select[0];
  endsequence
  a_pwrup_value: assert property ($fell(rst) |->
    conversion_configuration_q == `ACD_CFG_RESET)
    else $error("config not at reset value");
  a_se_unipolar: assert property (input_pairing |-> !conv_bipolar)
    else $error("bipolar while single-ended");
  a_reset_clears: assert property (alarm_clear |->
    ##[0:2] conversion_configuration_q == `ACD_CFG_RESET)
    else $error("reset bit left config");
  a_pick_chan: assert property (s_pick |->
    conv_channel_q == channel_select)
    else $error("wrong channel picked");
  a_range_top: assert property (conv_req_q && scan_select == 2'b00
    |-> conv_channel_q <= channel_select)
    else $error("scan past top channel");
  a_skip_ain3: assert property (conv_req_q && ain3_is_reference
    && !scan_select[0] |-> conv_channel_q != 2'd3)
    else $error("input three scanned");
  a_done_stores: assert property (s_fin |=> result_wr_q ##1 !result_wr_q)
    else $error("result not stored once");
  a_readback_en: assert property (mon_readback_en ==
    (conversion_configuration_q[4] && conversion_configuration_q[3]))
    else $error("readback enable wrong");
endmodule
`default_nettype wire

//--- dv/acd_bus_master.sv
// Two-wire bus master model driving the decoder's pins
`timescale 1ns/1ps
`default_nettype none
module acd_bus_master (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  // Pulled-up lines idle high; the clock stands still between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic start();
    @(posedge sys_clk) #2;
    #300 sda = 1'b1;
    #100 scl = 1'b1;
    #400 sda = 1'b0;
    #400 scl = 1'b0;
  endtask
  // Data moves late in the low phase, clear of the slave's ack release
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #300 sda = b[i];
      #100 scl = 1'b1;
      #400 scl = 1'b0;
    end
    #300 sda = 1'b1;
    #100 scl = 1'b1;
    #200 ack = ~sda_line;
    #200 scl = 1'b0;
  endtask
  task automatic stop();
    #300 sda = 1'b0;
    #100 scl = 1'b1;
    #400 sda = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the two-wire command decoder
`timescale 1ns/1ps
`default_nettype none
`include "acd_regs.vh"
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic conv_done = 1'b0;
  logic [3:0] rd_addr = 4'h0;
  logic scl, sda, sda_oe, bip, rb_en, a3ref, ref_pw, ext_clk, alarm, pwr;
  logic seq, req, wr, hs;
  logic [7:0] cfg_q, set_q, mon_dat;
  logic [3:0] mon_cnt;
  logic [1:0] ch;
  logic [15:0] hist;
  int failures = 0, n_checks = 0, n_wr = 0, cyc = 0, cd = 0;
  int n_alarm = 0, n_pw = 0;
  wire logic sda_line = sda & ~sda_oe;
  always #25 sys_clk = ~sys_clk;
  acd_bus_master i_mst (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl),
    .sda(sda));
  acd_decoder i_dut (.sys_clk(sys_clk), .rst(rst), .scl_in(scl),
    .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe), .addr_strap(1'b0),
    .conv_done(conv_done), .mon_rd_addr(rd_addr), .mon_rd_data(mon_dat),
    .conversion_configuration_q(cfg_q), .setup_q(set_q), .scan_select(),
    .channel_select(), .input_pairing(), .conv_bipolar(bip),
    .conv_ext_clock(ext_clk), .ain3_is_reference(a3ref),
    .ref_powered(ref_pw), .mon_readback_en(rb_en), .mon_count_q(mon_cnt),
    .alarm_clear(alarm), .hs_mode_q(hs), .adc_powered_q(pwr),
    .seq_active_q(seq), .conv_req_q(req), .conv_channel_q(ch),
    .result_wr_q(wr), .result_idx_q());
  // Converter stand-in answers three cycles after each request
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    cd <= req ? 3 : (cd > 0 ? cd - 1 : 0);
    conv_done <= #2 (cd == 1);
    if (wr) begin
      n_wr <= n_wr + 1;
      hist <= {hist[13:0], ch};
    end
    if (alarm) n_alarm <= n_alarm + 1;
    if (req && pwr) n_pw <= n_pw + 1;
    if (cyc == 40000) begin
      failures++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic send(input logic [7:0] q[$]);
    logic ack;
    i_mst.start();
    foreach (q[i]) begin
      i_mst.put_byte(q[i], ack);
      chk("ack", 16'h1, 16'(ack));
    end
    i_mst.stop();
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_write_fields();
    chk("cfg0", 16'h0001, 16'(cfg_q));
    chk("set0", 16'h0082, 16'(set_q));
    send('{8'h68, 8'h3E, 8'hF6});
    chk("cfg", 16'h003E, 16'(cfg_q));
    chk("set", 16'h00F6, 16'(set_q));
    chk("rb_bip", 16'h3, 16'({rb_en, bip}));
    chk("ref", 16'h6, 16'({a3ref, ref_pw, ext_clk}));
    send('{8'h68, 8'h3F});
    chk("bip_se", 16'h0, 16'(bip));
  endtask
  task automatic t_wrong_addr();
    logic ack;
    i_mst.start();
    i_mst.put_byte(8'h6E, ack);
    chk("nack", 16'h0, 16'(ack));
    chk("asleep", 16'h0, 16'(pwr));
    i_mst.put_byte(8'h05, ack);
    i_mst.stop();
    chk("cfg_kept", 16'h003F, 16'(cfg_q));
    i_mst.start();
    i_mst.put_byte(8'h68, ack);
    chk("wake", 16'h3, 16'({ack, pwr}));
    i_mst.stop();
    chk("sleep", 16'h0, 16'(pwr));
  endtask
  task automatic t_reset_bit();
    int a0;
    a0 = n_alarm;
    send('{8'h68, 8'hF4});
    chk("cfg_clr", 16'h0001, 16'(cfg_q));
    chk("set_kept", 16'h00F4, 16'(set_q));
    chk("alarm", 16'h1, 16'(n_alarm - a0));
  endtask
  task automatic t_monitor();
    logic [7:0] mv[3] = '{8'h11, 8'h22, 8'h53};
    send('{8'h68, 8'h83, mv[0], mv[1], mv[2]});
    chk("mon_cnt", 16'h3, 16'(mon_cnt));
    chk("cfg_kept", 16'h0001, 16'(cfg_q));
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk) #2 rd_addr = 4'(i);
      @(posedge sys_clk) #2;
      chk("mon_dat", 16'(mv[i]), 16'(mon_dat));
    end
  endtask
  // Starts a sequence by a read address and judges what was converted
  task automatic run_seq(input logic [7:0] c, s, input int n,
    input logic [15:0] h);
    int n0, p0;
    send('{8'h68, c, s});
    n0 = n_wr;
    p0 = n_pw;
    send('{8'h69});
    for (int k = 0; k < 400 && seq !== 1'b0; k++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    chk("n_res", 16'(n), 16'(n_wr - n0));
    chk("chans", h, hist & 16'((1 << (2 * n)) - 1));
    chk("pwr_req", 16'(n), 16'(n_pw - p0));
    chk("pwr_seq", 16'h0, 16'({pwr, seq}));
  endtask
  task automatic t_scan_range();
    run_seq(8'h07, 8'h82, 4, 16'h001B);
    run_seq(8'h07, 8'hA2, 3, 16'h0006);
  endtask
  task automatic t_scan_repeat();
    run_seq(8'h23, 8'h82, 8, 16'h5555);
  endtask
  task automatic t_scan_single();
    run_seq(8'h65, 8'h82, 1, 16'h0002);
  endtask
  // Bus-clocked single conversions repeat until the STOP
  task automatic t_ext_clock();
    int n0;
    send('{8'h68, 8'h65, 8'h8A});
    n0 = n_wr;
    send('{8'h69});
    repeat (8) @(posedge sys_clk);
    chk("ext_more", 16'h1, 16'(n_wr - n0 > 1));
    chk("ext_idle", 16'h0, 16'({pwr, seq}));
  endtask
  task automatic t_hs_mode();
    logic ack;
    i_mst.start();
    i_mst.put_byte(8'h08, ack);
    chk("hs_nack", 16'h0, 16'(ack));
    chk("hs_on", 16'h1, 16'(hs));
    i_mst.stop();
    chk("hs_off", 16'h0, 16'(hs));
  endtask
  // Monitor scan never ends by itself; a mid-run reset stops it
  task automatic t_scan_monitor();
    int n0;
    send('{8'h68, 8'h45, 8'h82});
    n0 = n_wr;
    send('{8'h69});
    for (int k = 0; k < 400 && n_wr - n0 < 8; k++) @(posedge sys_clk);
    chk("mon_n", 16'h8, 16'(n_wr - n0));
    chk("mon_ch", 16'h1861, hist);
    chk("mon_on", 16'h3, 16'({pwr, seq}));
    @(posedge sys_clk) #2 rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #2 rst = 1'b0;
    @(posedge sys_clk) #2;
    chk("rst_idle", 16'h0, 16'({pwr, seq}));
    chk("rst_cfg", 16'h0001, 16'(cfg_q));
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    #2 rst = 1'b0;
    repeat (5) @(posedge sys_clk);
    t_write_fields();
    t_wrong_addr();
    t_reset_bit();
    t_monitor();
    t_scan_range();
    t_scan_repeat();
    t_scan_single();
    t_ext_clock();
    t_hs_mode();
    t_scan_monitor();
    final_report();
  end
endmodule
bind acd_decoder acd_checker i_chk (.sys_clk, .rst, .conv_done,
  .conversion_configuration_q, .scan_select, .channel_select,
  .input_pairing, .conv_bipolar, .ain3_is_reference, .mon_readback_en,
  .alarm_clear, .seq_active_q, .conv_req_q, .conv_channel_q, .result_wr_q);
`default_nettype wire
